// ### rtl/rls_pkg.sv
package rls_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_LANES = 12;
  localparam int CAL_LEN = 256;
  localparam int CAL_CHUNK = 16;
  localparam int CAL_WORDS = CAL_LEN / 32;
  localparam int LOCK_COUNT = 64;
  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int CW_CAL_MSB = 55;
  localparam int CW_CAL_LSB = 40;
  localparam int CW_CAL_START = 56;
  localparam int CW_MU_MSB = 31;
  localparam int CW_MU_LSB = 24;
  localparam int FRAME_HI = 65;
  localparam int FRAME_LO = 64;
  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CMD = 12'h004;
  localparam logic [11:0] ADDR_LOCK = 12'h008;
  localparam logic [11:0] ADDR_SYNC = 12'h00c;
  localparam logic [11:0] ADDR_CRC = 12'h010;
  localparam logic [11:0] ADDR_MU = 12'h014;
  localparam logic [11:0] ADDR_CAL0 = 12'h020;
  localparam logic [11:0] ADDR_CAL7 = 12'h03c;
  localparam logic [11:0] CTRL_RESET = 12'hfff;
  localparam int CMD_CAL_CLEAR = 0;
  localparam int MU_PTR_LSB = 16;
  // Lane word alignment states
  typedef enum logic {LANE_HUNT, LANE_LOCKED} rls_lane_state_t;
endpackage : rls_pkg

// ### rtl/rls_lane.sv
`timescale 1ns/1ps
module rls_lane (
  input wire logic clk, // Local bus clock
  input wire logic rst_n, // Async reset, active low
  input wire logic lane_en, // Lane enabled by software
  input wire logic word_valid, // A 67-bit word arrived
  input wire logic [1:0] frame_bits, // Bits 65..64 of that word
  input wire logic mf_ok, // Good sync word seen
  input wire logic mf_err, // Bad sync word seen
  input wire logic scr_ok, // Good scrambler word seen
  input wire logic scr_err, // Bad scrambler word seen
  input wire logic diag_valid, // Diagnostic word arrived
  input wire logic diag_crc_good, // Its CRC32 matched
  output logic word_lock_reg, // Word boundary locked
  output logic synced_reg, // Fully synchronized
  output logic crc_ok_reg, // Latest CRC32 good
  output logic crc_fail_reg // One-clock CRC32 mismatch
);
  rls_pkg::rls_lane_state_t state_reg;
  logic [6:0] good_cnt_reg;
  logic mf_seen_reg;
  logic scr_seen_reg;
  logic pattern_ok;

  // Legal framing is 01 or 10
  assign pattern_ok = frame_bits[0] ^ frame_bits[1];

  // ----------------------------------------------------------------
  // Word boundary hunt
  // ----------------------------------------------------------------
  // Framing patterns only, no other word types looked at
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= rls_pkg::LANE_HUNT;
      good_cnt_reg <= 7'h00;
    end
    else if (!lane_en)
    begin
      state_reg <= rls_pkg::LANE_HUNT;
      good_cnt_reg <= 7'h00;
    end
    else if (word_valid)
    begin
      case (state_reg)
        rls_pkg::LANE_HUNT:
        begin
          if (!pattern_ok)
            good_cnt_reg <= 7'h00;
          else if (good_cnt_reg == 7'(rls_pkg::LOCK_COUNT - 1))
          begin
            state_reg <= rls_pkg::LANE_LOCKED;
            good_cnt_reg <= 7'h00;
          end
          else
            good_cnt_reg <= good_cnt_reg + 7'h01;
        end
        rls_pkg::LANE_LOCKED:
        begin
          if (!pattern_ok)
            state_reg <= rls_pkg::LANE_HUNT;
        end
        default:
          state_reg <= rls_pkg::LANE_HUNT;
      endcase
    end
  end

  // Lock flag registered from the state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      word_lock_reg <= 1'b0;
    else
      word_lock_reg <= lane_en && (state_reg == rls_pkg::LANE_LOCKED);
  end

  // ----------------------------------------------------------------
  // Sync and scrambler word tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mf_seen_reg <= 1'b0;
      scr_seen_reg <= 1'b0;
    end
    else if (state_reg != rls_pkg::LANE_LOCKED || !lane_en)
    begin
      mf_seen_reg <= 1'b0;
      scr_seen_reg <= 1'b0;
    end
    else
    begin
      if (mf_err)
        mf_seen_reg <= 1'b0;
      else if (mf_ok)
        mf_seen_reg <= 1'b1;
      if (scr_err)
        scr_seen_reg <= 1'b0;
      else if (scr_ok)
        scr_seen_reg <= 1'b1;
    end
  end

  // All three conditions for full sync
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      synced_reg <= 1'b0;
    else
      synced_reg <= lane_en && (state_reg == rls_pkg::LANE_LOCKED) && mf_seen_reg && scr_seen_reg;
  end

  // ----------------------------------------------------------------
  // Diagnostic word CRC32
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crc_ok_reg <= 1'b0;
      crc_fail_reg <= 1'b0;
    end
    else
    begin
      crc_fail_reg <= diag_valid && !diag_crc_good;
      if (diag_valid)
        crc_ok_reg <= diag_crc_good;
    end
  end
endmodule : rls_lane

// ### rtl/rls_top.sv
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module rls_top (
  input wire logic clk, // Local bus clock, 100 MHz
  input wire logic rst_n, // Async reset, active low
  // Lane receive events
  input wire logic [11:0] lane_word_valid, // Word arrived per lane
  input wire logic [23:0] lane_frame_bits, // Bits 65..64, two per lane
  input wire logic [11:0] lane_mf_ok, // Good sync word per lane
  input wire logic [11:0] lane_mf_err, // Bad sync word per lane
  input wire logic [11:0] lane_scr_ok, // Good scrambler word per lane
  input wire logic [11:0] lane_scr_err, // Bad scrambler word per lane
  input wire logic [11:0] lane_diag_valid, // Diagnostic word per lane
  input wire logic [11:0] lane_diag_crc_good, // Its CRC32 matched
  // Control word stream
  input wire logic ctl_word_valid, // Control word arrived
  input wire logic [63:0] ctl_word, // Control word payload
  input wire logic ctl_crc24_err, // CRC24 mismatch pulse
  input wire logic align_lost, // Lane alignment lost pulse
  // Status outputs
  output logic [11:0] diag_crc_ok_per_lane, // CRC32 valid per lane
  output logic [11:0] diag_crc_fail_pulse, // CRC32 error pulse
  output logic [255:0] rx_calendar_status_vec, // XON/XOFF per entry
  output logic [7:0] rx_mubits, // Multi-use field
  output logic rx_mubits_updated, // Multi-use update strobe
  output logic [11:0] rx_word_lock, // Word boundary lock
  output logic [11:0] rx_synced, // Full lane sync
  // APB slave
  input wire logic psel, // Select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Write
  input wire logic [11:0] paddr, // Byte address
  input wire logic [31:0] pwdata, // Write data
  output logic [31:0] prdata, // Read data
  output logic pready, // Ready
  output logic pslverr // Error on unmapped address
);
  logic [255:0] cal_reg;
  logic [8:0] cal_ptr_reg;
  logic [7:0] mu_reg;
  logic mu_upd_reg;
  logic [11:0] ctrl_reg;
  logic cal_clear_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [11:0] lock_w;
  logic [11:0] sync_w;
  logic [11:0] crc_ok_w;
  logic [11:0] crc_fail_w;
  logic cw_good;
  logic cal_kill;
  logic [8:0] cal_base;
  logic [15:0] cal_chunk;
  logic apb_setup;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Known register address
  function automatic logic addr_mapped(input logic [11:0] a);
    logic hit;
    hit = (a == rls_pkg::ADDR_CTRL) || (a == rls_pkg::ADDR_CMD) || (a == rls_pkg::ADDR_LOCK) ||
          (a == rls_pkg::ADDR_SYNC) || (a == rls_pkg::ADDR_CRC) || (a == rls_pkg::ADDR_MU) ||
          ((a >= rls_pkg::ADDR_CAL0) && (a <= rls_pkg::ADDR_CAL7) && (a[1:0] == 2'h0));
    return hit;
  endfunction : addr_mapped

  // Calendar word index of an address
  function automatic logic [2:0] cal_index(input logic [11:0] a);
    logic [11:0] off;
    off = a - rls_pkg::ADDR_CAL0;
    return off[4:2];
  endfunction : cal_index

  assign apb_setup = psel && !penable;
  assign cw_good = ctl_word_valid && !ctl_crc24_err;
  assign cal_kill = ctl_crc24_err || align_lost || cal_clear_reg;
  // Start bit restarts the calendar at entry 0
  assign cal_base = ctl_word[rls_pkg::CW_CAL_START] ? 9'h000 : cal_ptr_reg;
  // Bit 55 is the first entry, so reverse into vector order
  assign cal_chunk = {<<{ctl_word[rls_pkg::CW_CAL_MSB:rls_pkg::CW_CAL_LSB]}};

  // ----------------------------------------------------------------
  // Per-lane status
  // ----------------------------------------------------------------
  for (genvar g = 0; g < rls_pkg::NUM_LANES; g++)
  begin : g_lane
    rls_lane u_lane (
      .clk(clk),
      .rst_n(rst_n),
      .lane_en(ctrl_reg[g]),
      .word_valid(lane_word_valid[g]),
      .frame_bits(lane_frame_bits[2*g+1:2*g]),
      .mf_ok(lane_mf_ok[g]),
      .mf_err(lane_mf_err[g]),
      .scr_ok(lane_scr_ok[g]),
      .scr_err(lane_scr_err[g]),
      .diag_valid(lane_diag_valid[g]),
      .diag_crc_good(lane_diag_crc_good[g]),
      .word_lock_reg(lock_w[g]),
      .synced_reg(sync_w[g]),
      .crc_ok_reg(crc_ok_w[g]),
      .crc_fail_reg(crc_fail_w[g])
    );
  end

  // Lane outputs straight from lane flip-flops
  assign diag_crc_ok_per_lane = crc_ok_w;
  assign diag_crc_fail_pulse = crc_fail_w;
  assign rx_word_lock = lock_w;
  assign rx_synced = sync_w;

  // ----------------------------------------------------------------
  // Flow-control calendar
  // ----------------------------------------------------------------
  // Fill pointer, parks at 256 once full or after a kill
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cal_ptr_reg <= 9'h100;
    else if (cal_kill)
      cal_ptr_reg <= 9'h100;
    else if (cw_good && !cal_base[8])
      cal_ptr_reg <= cal_base + 9'(rls_pkg::CAL_CHUNK);
  end

  // One writer per sixteen-entry chunk, all on the bus clock
  for (genvar c = 0; c < rls_pkg::CAL_LEN / rls_pkg::CAL_CHUNK; c++)
  begin : g_cal
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        cal_reg[c*16 +: 16] <= 16'h0000;
      else if (cal_kill)
        cal_reg[c*16 +: 16] <= 16'h0000;
      else if (cw_good && !cal_base[8] && (cal_base[7:4] == 4'(c)))
        cal_reg[c*16 +: 16] <= cal_chunk;
    end
  end

  assign rx_calendar_status_vec = cal_reg;

  // ----------------------------------------------------------------
  // Multi-use field
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mu_reg <= 8'h00;
      mu_upd_reg <= 1'b0;
    end
    else
    begin
      mu_upd_reg <= cw_good;
      if (cw_good)
        mu_reg <= ctl_word[rls_pkg::CW_MU_MSB:rls_pkg::CW_MU_LSB];
    end
  end

  assign rx_mubits = mu_reg;
  assign rx_mubits_updated = mu_upd_reg;

  // ----------------------------------------------------------------
  // APB writes
  // ----------------------------------------------------------------
  // Lane enable mask
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_reg <= rls_pkg::CTRL_RESET;
    else if (psel && penable && pready_reg && pwrite && (paddr == rls_pkg::ADDR_CTRL))
      ctrl_reg <= pwdata[11:0];
  end

  // Self-clearing calendar clear command
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cal_clear_reg <= 1'b0;
    else
      cal_clear_reg <= psel && penable && pready_reg && pwrite && (paddr == rls_pkg::ADDR_CMD) &&
                       pwdata[rls_pkg::CMD_CAL_CLEAR];
  end

  // ----------------------------------------------------------------
  // APB reads and handshake
  // ----------------------------------------------------------------
  // Answer prepared in setup, shown in first access cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= apb_setup;
      pslverr_reg <= apb_setup && !addr_mapped(paddr);
    end
  end

  // Read data mux
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata_reg <= 32'h0000_0000;
    else if (apb_setup && !pwrite)
    begin
      prdata_reg <= 32'h0000_0000;
      if (paddr == rls_pkg::ADDR_CTRL)
        prdata_reg <= {20'h00000, ctrl_reg};
      else if (paddr == rls_pkg::ADDR_LOCK)
        prdata_reg <= {20'h00000, lock_w};
      else if (paddr == rls_pkg::ADDR_SYNC)
        prdata_reg <= {20'h00000, sync_w};
      else if (paddr == rls_pkg::ADDR_CRC)
        prdata_reg <= {20'h00000, crc_ok_w};
      else if (paddr == rls_pkg::ADDR_MU)
        prdata_reg <= {7'h00, cal_ptr_reg, 8'h00, mu_reg};
      else if (addr_mapped(paddr) && (paddr >= rls_pkg::ADDR_CAL0))
        prdata_reg <= cal_reg[cal_index(paddr)*32 +: 32];
    end
    else if (apb_setup)
      prdata_reg <= 32'h0000_0000;
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
endmodule : rls_top

// ### sim/rls_far_tx.sv
`timescale 1ns/1ps
module rls_far_tx (
  input wire logic clk, // Local bus clock
  input wire logic go, // Start a burst
  input wire logic [7:0] count, // Words in burst
  input wire logic bad_last, // Last word framed illegally
  output logic [11:0] word_valid, // Word strobe per lane
  output logic [23:0] frame_bits, // Framing per lane
  output logic busy // Burst in flight
);
  logic [7:0] left_reg = 8'h0;
  logic [23:0] noise_reg = 24'h0;
  // Burst counter; idle framing lines toggle
  always_ff @(posedge clk)
  begin
    noise_reg <= ~noise_reg;
    if (go)
      left_reg <= count;
    else if (left_reg != 8'h0)
      left_reg <= left_reg - 8'h1;
  end
  // Lane 0 words, legal 01/10 or a final 11
  always_comb
  begin
    busy = (left_reg != 8'h0);
    word_valid = {11'h0, busy};
    frame_bits = noise_reg;
    if (busy)
      frame_bits[1:0] = (bad_last && left_reg == 8'h1) ? 2'b11 : {left_reg[0], ~left_reg[0]};
  end
endmodule : rls_far_tx

// ### sim/rls_top_sva.sv
`timescale 1ns/1ps
module rls_top_sva (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [11:0] lane_word_valid, // Word strobes
  input wire logic [23:0] lane_frame_bits, // Framing
  input wire logic [11:0] lane_diag_valid, // Diag strobes
  input wire logic [11:0] lane_diag_crc_good, // Diag CRC good
  input wire logic ctl_word_valid, // Control strobe
  input wire logic [63:0] ctl_word, // Control payload
  input wire logic ctl_crc24_err, // CRC24 error
  input wire logic align_lost, // Alignment lost
  input wire logic [11:0] diag_crc_ok_per_lane, // CRC ok
  input wire logic [11:0] diag_crc_fail_pulse, // CRC fail
  input wire logic [255:0] rx_calendar_status_vec, // Calendar
  input wire logic [7:0] rx_mubits, // Multi-use
  input wire logic rx_mubits_updated, // Strobe
  input wire logic [11:0] rx_word_lock, // Lock
  input wire logic [11:0] rx_synced, // Sync
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pready // Ready
);
  logic [11:0] bad_w;
  logic [7:0] mu_w;
  logic [6:0] lk_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Cause terms
  assign bad_w = lane_diag_valid & ~lane_diag_crc_good;
  assign mu_w = ctl_word[31:24];
  // Consecutive legal framing count, lane 0
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      lk_cnt <= 7'h0;
    else if (lane_word_valid[0])
      lk_cnt <= (^lane_frame_bits[1:0]) ? ((lk_cnt == 7'h40) ? lk_cnt : lk_cnt + 7'h1) : 7'h0;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_cw;
    ctl_word_valid && !ctl_crc24_err;
  endsequence
  property p_apb; s_setup |=> pready; endproperty
  a_apb: assert property (p_apb) else $error("no ready after setup");
  property p_fail; bad_w != 12'h0 |=> diag_crc_fail_pulse == $past(bad_w) ##1 (diag_crc_fail_pulse & $past(bad_w,2)) == 12'h0 || $past(bad_w) != 12'h0; endproperty
  a_fail: assert property (p_fail) else $error("crc fail pulse wrong");
  property p_ok; lane_diag_valid != 12'h0 |=> ((diag_crc_ok_per_lane ^ $past(lane_diag_crc_good)) & $past(lane_diag_valid)) == 12'h0; endproperty
  a_ok: assert property (p_ok) else $error("crc ok flag wrong");
  property p_kill; ctl_crc24_err || align_lost |=> rx_calendar_status_vec == 256'h0; endproperty
  a_kill: assert property (p_kill) else $error("calendar not cleared");
  property p_mu; s_cw |=> rx_mubits == $past(mu_w) && rx_mubits_updated; endproperty
  a_mu: assert property (p_mu) else $error("multi-use field wrong");
  property p_upd; rx_mubits_updated |-> $past(ctl_word_valid) && !$past(ctl_crc24_err); endproperty
  a_upd: assert property (p_upd) else $error("stray update strobe");
  property p_hold; !ctl_word_valid && !ctl_crc24_err && !align_lost && !psel && !$past(psel) |=> $stable(rx_calendar_status_vec); endproperty
  a_hold: assert property (p_hold) else $error("calendar changed idle");
  property p_sync; (rx_synced & ~rx_word_lock) == 12'h0; endproperty
  a_sync: assert property (p_sync) else $error("synced without lock");
  property p_lock; $rose(rx_word_lock[0]) |-> lk_cnt == 7'h40; endproperty
  a_lock: assert property (p_lock) else $error("early word lock");
endmodule : rls_top_sva
bind rls_top rls_top_sva u_sva (.clk, .rst_n, .lane_word_valid, .lane_frame_bits, .lane_diag_valid,
  .lane_diag_crc_good, .ctl_word_valid, .ctl_word, .ctl_crc24_err, .align_lost, .diag_crc_ok_per_lane,
  .diag_crc_fail_pulse, .rx_calendar_status_vec, .rx_mubits, .rx_mubits_updated, .rx_word_lock,
  .rx_synced, .psel, .penable, .pready);

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic st; logic [15:0] ent; logic [7:0] mu; logic [31:0] vec;} rls_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic bad_last = 1'b0;
  logic [7:0] count = 8'h0;
  logic busy;
  logic [11:0] lane_word_valid, lane_mf_ok = 12'h0, lane_mf_err = 12'h0, lane_scr_ok = 12'h0;
  logic [11:0] lane_scr_err = 12'h0, lane_diag_valid = 12'h0, lane_diag_crc_good = 12'h0;
  logic [23:0] lane_frame_bits;
  logic ctl_word_valid = 1'b0, ctl_crc24_err = 1'b0, align_lost = 1'b0;
  logic [63:0] ctl_word = 64'h0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [11:0] diag_crc_ok_per_lane, diag_crc_fail_pulse, rx_word_lock, rx_synced;
  logic [255:0] rx_calendar_status_vec;
  logic [7:0] rx_mubits;
  logic rx_mubits_updated, pready, pslverr, er;
  logic [31:0] prdata, rd;
  int errors = 0;
  int n_checks = 0;
  rls_row_t rows [3] = '{{1'b1, 16'h8000, 8'ha5, 32'h1}, {1'b0, 16'h0001, 8'h3c, 32'h80000001},
    {1'b1, 16'hf00f, 8'h00, 32'h8000f00f}};
  // Clock
  always #5 clk = ~clk;
  rls_far_tx far (.clk, .go, .count, .bad_last, .word_valid(lane_word_valid),
    .frame_bits(lane_frame_bits), .busy);
  rls_top dut (.clk, .rst_n, .lane_word_valid, .lane_frame_bits, .lane_mf_ok, .lane_mf_err, .lane_scr_ok,
    .lane_scr_err, .lane_diag_valid, .lane_diag_crc_good, .ctl_word_valid, .ctl_word, .ctl_crc24_err,
    .align_lost, .diag_crc_ok_per_lane, .diag_crc_fail_pulse, .rx_calendar_status_vec, .rx_mubits,
    .rx_mubits_updated, .rx_word_lock, .rx_synced, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  task automatic check(input logic [287:0] seen, input logic [287:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
    begin
      errors++;
      finish_test();
    end
  endtask : apb
  task automatic burst(input logic [7:0] n, input logic bad);
    int k;
    @(posedge clk);
    go <= 1'b1;
    count <= n;
    bad_last <= bad;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 300 && busy !== 1'b0; k++)
      @(posedge clk);
    #1;
    if (k == 300)
    begin
      errors++;
      finish_test();
    end
  endtask : burst
  task automatic send(input logic st, input logic [15:0] e, input logic [7:0] m, input logic err);
    @(posedge clk);
    ctl_word_valid <= 1'b1;
    ctl_word <= {7'h0, st, e, 8'h0, m, 24'h0};
    ctl_crc24_err <= err;
    @(posedge clk);
    ctl_word_valid <= 1'b0;
    ctl_crc24_err <= 1'b0;
    #1;
  endtask : send
  // Main sequence
  initial
  begin
    tick(3);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      send(rows[i].st, rows[i].ent, rows[i].mu, 1'b0);
      check({rx_mubits, rx_mubits_updated}, {rows[i].mu, 1'b1});
      check(rx_calendar_status_vec, rows[i].vec);
      tick(1);
      check(rx_mubits_updated, 1'b0);
    end
    $display("table done");
    for (int i = 0; i < 17; i++)
      send(i == 0, (i < 16) ? 16'hffff : 16'h0, 8'h11, 1'b0);
    check(rx_calendar_status_vec, {256{1'b1}});
    send(1'b1, 16'h0, 8'h33, 1'b1);
    check({rx_calendar_status_vec, rx_mubits_updated}, 257'h0);
    send(1'b1, 16'h8000, 8'h44, 1'b0);
    align_lost <= 1'b1;
    tick(1);
    align_lost <= 1'b0;
    tick(1);
    check(rx_calendar_status_vec, 256'h0);
    lane_diag_valid <= 12'hfff;
    lane_diag_crc_good <= 12'h0f0;
    tick(1);
    lane_diag_valid <= 12'h0;
    check({diag_crc_ok_per_lane, diag_crc_fail_pulse}, 24'h0f0f0f);
    tick(1);
    check({diag_crc_ok_per_lane, diag_crc_fail_pulse}, 24'h0f0000);
    $display("status done");
    burst(8'd64, 1'b1);
    tick(2);
    check(rx_word_lock, 12'h0);
    burst(8'd63, 1'b0);
    check(rx_word_lock, 12'h0);
    burst(8'd1, 1'b0);
    tick(1);
    check({rx_word_lock, rx_synced}, 24'h001000);
    lane_mf_ok <= 12'h1;
    lane_scr_ok <= 12'h1;
    tick(1);
    lane_mf_ok <= 12'h0;
    lane_scr_ok <= 12'h0;
    tick(2);
    check(rx_synced, 12'h1);
    lane_mf_err <= 12'h1;
    tick(1);
    lane_mf_err <= 12'h0;
    tick(2);
    check({rx_word_lock, rx_synced}, 24'h001000);
    $display("lanes done");
    apb(1'b0, rls_pkg::ADDR_CTRL, 32'h0);
    check({er, rd}, 33'hfff);
    apb(1'b0, rls_pkg::ADDR_LOCK, 32'h0);
    check({er, rd}, 33'h1);
    send(1'b1, 16'h8000, 8'h5a, 1'b0);
    apb(1'b0, rls_pkg::ADDR_CAL0, 32'h0);
    check({er, rd}, 33'h1);
    apb(1'b0, rls_pkg::ADDR_MU, 32'h0);
    check({er, rd}, 33'h0010005a);
    apb(1'b0, rls_pkg::ADDR_CRC, 32'h0);
    check({er, rd}, 33'h0f0);
    apb(1'b1, rls_pkg::ADDR_CMD, 32'h1);
    apb(1'b0, rls_pkg::ADDR_CAL0, 32'h0);
    check({er, rd}, 33'h0);
    apb(1'b1, 12'h100, 32'h5);
    check(er, 1'b1);
    apb(1'b0, 12'h100, 32'h0);
    check({er, rd}, 33'h100000000);
    apb(1'b1, rls_pkg::ADDR_CTRL, 32'h0);
    apb(1'b0, rls_pkg::ADDR_CTRL, 32'h0);
    check({er, rd, rx_word_lock}, 45'h0);
    apb(1'b1, rls_pkg::ADDR_CTRL, 32'hfff);
    $display("bus done");
    rst_n <= 1'b0;
    tick(1);
    check({diag_crc_ok_per_lane, rx_mubits, rx_mubits_updated, rx_word_lock}, 33'h0);
    rst_n <= 1'b1;
    tick(2);
    check({diag_crc_ok_per_lane, rx_mubits, rx_synced, rx_calendar_status_vec}, 288'h0);
    $display("reset done");
    finish_test();
  end
endmodule : testbench
